/* rtl/itb_pkg.sv */
package itb_pkg;

  // Sizes
  localparam int N_UART_DEF  = 2;
  localparam int N_GROUP     = 3;
  localparam int VEC_W       = 4;
  localparam int UART_COND_N = 6;
  localparam int SIM_COND_N  = 4;
  localparam int LV_GROUP    = 2;

  // Time base fields
  localparam int TB_CNT_W    = 15;
  localparam int TB_SEL_W    = 3;
  localparam int TB_BASE_EXP = 8;
  localparam int TB_RUN_BIT  = 7;
  localparam int TB_SEL_LSB  = 0;

  // Prescaler source codes
  localparam int         PSC_SEL_W     = 2;
  localparam logic [1:0] PSC_SYS       = 2'h0;
  localparam logic [1:0] PSC_SYS_DIV4  = 2'h1;
  localparam logic [1:0] PSC_DIV4_LAST = 2'h3;

  // Register byte addresses
  localparam logic [7:0] ADDR_TB0_CTRL = 8'h00;
  localparam logic [7:0] ADDR_TB1_CTRL = 8'h04;
  localparam logic [7:0] ADDR_PSC      = 8'h08;
  localparam logic [7:0] ADDR_ENABLE   = 8'h0c;
  localparam logic [7:0] ADDR_FLAG     = 8'h10;
  localparam logic [7:0] ADDR_STATUS   = 8'h14;

  // Bit positions in enable, flag and status words
  localparam int EN_GLOBAL_BIT = 0;
  localparam int EN_SRC_LSB    = 1;
  localparam int EN_LV_BIT     = 16;
  localparam int FLAG_LV_BIT   = 16;
  localparam int ST_VEC_LSB    = 0;
  localparam int ST_REQ_BIT    = 8;
  localparam int ST_FULL_BIT   = 9;

  // Reset values
  localparam logic [7:0]           TB_CTRL_RST = 8'h00;
  localparam logic [PSC_SEL_W-1:0] PSC_SEL_RST = 2'h0;

  typedef enum logic {
    BUS_IDLE,
    BUS_READ
  } itb_bus_e;

  // Count mask of one period: 2^(8+sel) ticks
  function automatic logic [TB_CNT_W-1:0] itb_period_mask(input logic [TB_SEL_W-1:0] sel);
    logic [31:0] full;
    full = (32'h1 << (TB_BASE_EXP + 32'(sel))) - 32'h1;
    itb_period_mask = full[TB_CNT_W-1:0];
  endfunction : itb_period_mask

endpackage : itb_pkg

/* rtl/itb_timebase.sv */
module itb_timebase
  import itb_pkg::*;
(
  input  wire logic                hclk,       // System clock
  input  wire logic                hresetn,    // Async reset, active low
  input  wire logic                tick,       // Prescaler clock enable
  input  wire logic                run,        // Generator enable
  input  wire logic [TB_SEL_W-1:0] period_sel, // Period code
  output logic                     overflow    // One-cycle overflow pulse
);

  logic [TB_CNT_W-1:0] cnt_q;
  logic                wrap;

  // Masked compare lets a shorter period take effect at once
  assign wrap = tick && run &&
                ((cnt_q & itb_period_mask(period_sel)) == itb_period_mask(period_sel));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= '0;
    end else if (!run) begin
      cnt_q <= '0;
    end else if (wrap) begin
      cnt_q <= '0;
    end else if (tick) begin
      cnt_q <= cnt_q + 15'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      overflow <= 1'b0;
    end else begin
      overflow <= wrap;
    end
  end

  chk_stop_clears: assert property (@(posedge hclk) disable iff (!hresetn)
    !run |=> (cnt_q == '0) && !overflow)
    else $error("time base counts while disabled");

  chk_wrap_at_period: assert property (@(posedge hclk) disable iff (!hresetn)
    overflow |-> $past(run) && $past(tick) &&
                 (($past(cnt_q) & itb_period_mask($past(period_sel))) ==
                  itb_period_mask($past(period_sel))))
    else $error("time base overflow at wrong count");

endmodule : itb_timebase

/* rtl/itb_top.sv */
// Local design decisions: the AHB-Lite slave port and the placing of the registers.
module itb_top
  import itb_pkg::*;
#(
  parameter int N_UART = N_UART_DEF
)(
  input  wire logic                          hclk,                    // System clock
  input  wire logic                          hresetn,                 // Async reset, active low
  input  wire logic                          hsel,                    // Slave select
  input  wire logic [31:0]                   haddr,                   // Byte address
  input  wire logic [1:0]                    htrans,                  // Transfer type
  input  wire logic                          hwrite,                  // Write when high
  input  wire logic [2:0]                    hsize,                   // Transfer size
  input  wire logic [31:0]                   hwdata,                  // Write data
  input  wire logic                          hready,                  // Bus ready
  output logic                               hreadyout,               // Slave ready
  output logic                               hresp,                   // Always OKAY
  output logic [31:0]                        hrdata,                  // Read data
  input  wire logic                          sub_clk_tick,            // Subsidiary clock enable
  input  wire logic [N_UART*UART_COND_N-1:0] uart_event,              // Serial port conditions
  input  wire logic [SIM_COND_N-1:0]         sim_event,               // Serial module events
  input  wire logic                          spi_event,               // SPI byte done
  input  wire logic [N_GROUP-1:0]            group_member_evt,        // Timer/EEPROM flag sets
  input  wire logic                          lv_supply_low,           // Supply below threshold
  input  wire logic                          low_voltage_sense_input, // Sense input low
  input  wire logic                          cpu_stack_full,          // Call stack full
  input  wire logic                          cpu_irq_ack,             // Vector taken pulse
  input  wire logic                          cpu_reti,                // Return re-enables
  output logic                               irq_req,                 // Request to core
  output logic [VEC_W-1:0]                   irq_vector,              // Winning source index
  output logic                               wake                     // Wake-up pulse
);

  localparam int IDX_TB0  = 0;
  localparam int IDX_TB1  = 1;
  localparam int IDX_UART = 2;
  localparam int IDX_SIM  = IDX_UART + N_UART;
  localparam int IDX_SPI  = IDX_SIM + 1;
  localparam int IDX_MF   = IDX_SPI + 1;
  localparam int NSRC     = IDX_MF + N_GROUP;

  itb_bus_e    bus_q;
  logic        wr_pend_q;
  logic [7:0]  addr_q;
  logic        a_valid;
  logic        wr_en;
  logic                    tb0_run_q;
  logic [TB_SEL_W-1:0]     tb0_sel_q;
  logic                    tb1_run_q;
  logic [TB_SEL_W-1:0]     tb1_sel_q;
  logic [PSC_SEL_W-1:0]    psc_sel_q;
  logic                    global_q;
  logic [NSRC-1:0]         src_en_q;
  logic                    lv_en_q;
  logic [NSRC-1:0]         req_q;
  logic [NSRC-1:0]         req_d;
  logic                    lv_flag_q;
  logic                    lv_flag_d;
  logic                    lv_lvl_q;
  logic [NSRC-1:0]         set_vec;
  logic [NSRC-1:0]         ack_clr;
  logic [NSRC-1:0]         sw_clr;
  logic                    ack_take;
  logic [1:0]              div4_q;
  logic                    psc_tick;
  logic [1:0]              tb_ovf;
  logic [NSRC-1:0]         pend;
  logic                    win_any;
  logic [VEC_W-1:0]        win_idx;
  logic [31:0]             rd_mux;

  assign a_valid   = hsel && hready && htrans[1];
  assign wr_en     = wr_pend_q;
  assign hreadyout = (bus_q == BUS_IDLE);
  assign hresp     = 1'b0;

  // Reads take one wait state so the data come from a register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_q     <= BUS_IDLE;
      wr_pend_q <= 1'b0;
      addr_q    <= 8'h00;
    end else begin
      wr_pend_q <= a_valid && hwrite;
      if (a_valid) begin
        addr_q <= haddr[7:0];
      end
      unique case (bus_q)
        BUS_IDLE: begin
          if (a_valid && !hwrite) begin
            bus_q <= BUS_READ;
          end
        end
        BUS_READ: begin
          bus_q <= BUS_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    rd_mux = 32'h0;
    unique case (addr_q)
      ADDR_TB0_CTRL: begin
        rd_mux[TB_RUN_BIT]                  = tb0_run_q;
        rd_mux[TB_SEL_LSB +: TB_SEL_W]      = tb0_sel_q;
      end
      ADDR_TB1_CTRL: begin
        rd_mux[TB_RUN_BIT]                  = tb1_run_q;
        rd_mux[TB_SEL_LSB +: TB_SEL_W]      = tb1_sel_q;
      end
      ADDR_PSC: begin
        rd_mux[PSC_SEL_W-1:0]               = psc_sel_q;
      end
      ADDR_ENABLE: begin
        rd_mux[EN_GLOBAL_BIT]               = global_q;
        rd_mux[EN_SRC_LSB +: NSRC]          = src_en_q;
        rd_mux[EN_LV_BIT]                   = lv_en_q;
      end
      ADDR_FLAG: begin
        rd_mux[NSRC-1:0]                    = req_q;
        rd_mux[FLAG_LV_BIT]                 = lv_flag_q;
      end
      ADDR_STATUS: begin
        rd_mux[ST_VEC_LSB +: VEC_W]         = irq_vector;
        rd_mux[ST_REQ_BIT]                  = irq_req;
        rd_mux[ST_FULL_BIT]                 = cpu_stack_full;
      end
      default: begin
        rd_mux = 32'h0;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
    end else if (bus_q == BUS_READ) begin
      hrdata <= rd_mux;
    end
  end

  // Time base and prescaler controls; unused control bits are never stored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tb0_run_q <= TB_CTRL_RST[TB_RUN_BIT];
      tb0_sel_q <= TB_CTRL_RST[TB_SEL_LSB +: TB_SEL_W];
      tb1_run_q <= TB_CTRL_RST[TB_RUN_BIT];
      tb1_sel_q <= TB_CTRL_RST[TB_SEL_LSB +: TB_SEL_W];
      psc_sel_q <= PSC_SEL_RST;
    end else if (wr_en) begin
      if (addr_q == ADDR_TB0_CTRL) begin
        tb0_run_q <= hwdata[TB_RUN_BIT];
        tb0_sel_q <= hwdata[TB_SEL_LSB +: TB_SEL_W];
      end
      if (addr_q == ADDR_TB1_CTRL) begin
        tb1_run_q <= hwdata[TB_RUN_BIT];
        tb1_sel_q <= hwdata[TB_SEL_LSB +: TB_SEL_W];
      end
      if (addr_q == ADDR_PSC) begin
        psc_sel_q <= hwdata[PSC_SEL_W-1:0];
      end
    end
  end

  // Source enables
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      src_en_q <= '0;
      lv_en_q  <= 1'b0;
    end else if (wr_en && addr_q == ADDR_ENABLE) begin
      src_en_q <= hwdata[EN_SRC_LSB +: NSRC];
      lv_en_q  <= hwdata[EN_LV_BIT];
    end
  end

  // Global enable: service clears it, return sets it, software may write it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      global_q <= 1'b0;
    end else if (ack_take) begin
      global_q <= 1'b0;
    end else if (cpu_reti) begin
      global_q <= 1'b1;
    end else if (wr_en && addr_q == ADDR_ENABLE) begin
      global_q <= hwdata[EN_GLOBAL_BIT];
    end
  end

  // Prescaler clock enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div4_q <= 2'h0;
    end else begin
      div4_q <= div4_q + 2'h1;
    end
  end

  always_comb begin
    if (psc_sel_q == PSC_SYS) begin
      psc_tick = 1'b1;
    end else if (psc_sel_q == PSC_SYS_DIV4) begin
      psc_tick = (div4_q == PSC_DIV4_LAST);
    end else begin
      psc_tick = sub_clk_tick;
    end
  end

  itb_timebase u_tb0 (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .tick       (psc_tick),
    .run        (tb0_run_q),
    .period_sel (tb0_sel_q),
    .overflow   (tb_ovf[0])
  );

  itb_timebase u_tb1 (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .tick       (psc_tick),
    .run        (tb1_run_q),
    .period_sel (tb1_sel_q),
    .overflow   (tb_ovf[1])
  );

  // Flag sources
  assign lv_flag_d = lv_flag_q && !(wr_en && addr_q == ADDR_FLAG && hwdata[FLAG_LV_BIT]) ||
                     ((lv_supply_low || low_voltage_sense_input) && !lv_lvl_q);

  always_comb begin
    set_vec          = '0;
    set_vec[IDX_TB0] = tb_ovf[0];
    set_vec[IDX_TB1] = tb_ovf[1];
    for (int u = 0; u < N_UART; u++) begin
      set_vec[IDX_UART+u] = |uart_event[u*UART_COND_N +: UART_COND_N];
    end
    set_vec[IDX_SIM] = |sim_event;
    set_vec[IDX_SPI] = spi_event;
    for (int g = 0; g < N_GROUP; g++) begin
      set_vec[IDX_MF+g] = group_member_evt[g];
    end
    set_vec[IDX_MF+LV_GROUP] = group_member_evt[LV_GROUP] ||
                               (lv_en_q && lv_flag_d && !lv_flag_q);
  end

  assign ack_take = cpu_irq_ack && irq_req;
  assign sw_clr   = (wr_en && addr_q == ADDR_FLAG) ? hwdata[NSRC-1:0] : '0;

  always_comb begin
    ack_clr = '0;
    if (ack_take) begin
      ack_clr[irq_vector] = 1'b1;
    end
  end

  // A new event in the same cycle as a clear keeps the flag set
  assign req_d = (req_q & ~sw_clr & ~ack_clr) | set_vec;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_q     <= '0;
      lv_flag_q <= 1'b0;
      lv_lvl_q  <= 1'b0;
    end else begin
      req_q     <= req_d;
      lv_flag_q <= lv_flag_d;
      lv_lvl_q  <= lv_supply_low || low_voltage_sense_input;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake <= 1'b0;
    end else begin
      wake <= |(req_d & ~req_q) || (lv_flag_d && !lv_flag_q);
    end
  end

  // Arbitration: lowest index wins
  assign pend = req_q & src_en_q & {NSRC{global_q && !cpu_stack_full}};

  always_comb begin
    win_any = 1'b0;
    win_idx = '0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (pend[i]) begin
        win_any = 1'b1;
        win_idx = VEC_W'(i);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_req    <= 1'b0;
      irq_vector <= '0;
    end else begin
      irq_req    <= win_any && !ack_take && !cpu_stack_full;
      irq_vector <= win_idx;
    end
  end

  sequence s_div4_run;
    (psc_sel_q == PSC_SYS_DIV4 && psc_tick) ##1 (psc_sel_q == PSC_SYS_DIV4) [*4];
  endsequence

  chk_div4_spacing: assert property (@(posedge hclk) disable iff (!hresetn)
    s_div4_run |-> psc_tick && !$past(psc_tick) && !$past(psc_tick, 2) && !$past(psc_tick, 3))
    else $error("divide-by-four tick spacing wrong");
  chk_rsvd_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    (bus_q == BUS_READ && (addr_q == ADDR_TB0_CTRL || addr_q == ADDR_TB1_CTRL))
      |=> hrdata[6:3] == 4'h0)
    else $error("unused control bits read nonzero");
  chk_ack_clears: assert property (@(posedge hclk) disable iff (!hresetn)
    ack_take |=> !global_q && !irq_req ##1 !irq_req)
    else $error("service did not clear global enable");
  chk_stack_block: assert property (@(posedge hclk) disable iff (!hresetn)
    cpu_stack_full |=> !irq_req)
    else $error("request raised with stack full");
  chk_need_enable: assert property (@(posedge hclk) disable iff (!hresetn)
    irq_req |-> $past(global_q) && $past(src_en_q[win_idx]) && $past(req_q[win_idx]))
    else $error("request without enable or flag");
  chk_spi_sets: assert property (@(posedge hclk) disable iff (!hresetn)
    spi_event |=> req_q[IDX_SPI])
    else $error("spi event did not set flag");
  chk_group_sets: assert property (@(posedge hclk) disable iff (!hresetn)
    group_member_evt[0] |=> req_q[IDX_MF])
    else $error("group member did not set group flag");
  chk_lv_kept: assert property (@(posedge hclk) disable iff (!hresetn)
    (ack_take && lv_flag_q && !(wr_en && addr_q == ADDR_FLAG)) |=> lv_flag_q)
    else $error("service cleared low-voltage flag");
  chk_wake_rise: assert property (@(posedge hclk) disable iff (!hresetn)
    (|(req_q & ~$past(req_q))) |-> wake)
    else $error("flag rise without wake pulse");
  chk_one_pending: assert property (@(posedge hclk) disable iff (!hresetn)
    (ack_take && $countones(pend) > 1 && set_vec == '0 && sw_clr == '0)
      |=> $countones(req_q) == $countones($past(req_q)) - 1)
    else $error("service cleared more than one flag");

endmodule : itb_top

/* dv/itb_cpu_model.sv */
module itb_cpu_model
  import itb_pkg::*;
(
  input  wire logic             hclk,           // System clock
  input  wire logic             hresetn,        // Async reset, active low
  input  wire logic             irq_req,        // Request from controller
  input  wire logic [VEC_W-1:0] irq_vector,     // Offered vector
  input  wire logic             full_cmd,       // Bench holds the stack full
  input  wire logic [3:0]       ack_wait,       // Extra cycles before taking
  output logic                  cpu_irq_ack,    // Vector taken pulse
  output logic                  cpu_reti,       // Return pulse
  output logic                  cpu_stack_full, // Stack full level
  output logic [VEC_W-1:0]      taken_vec,      // Last vector taken
  output int                    taken_cnt       // Vectors taken so far
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] wait_q;
  logic [4:0] busy_q;

  assign cpu_stack_full = full_cmd;

  // Service routine runs busy_q cycles, then returns and re-enables
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cpu_irq_ack <= 1'b0;
      cpu_reti    <= 1'b0;
      taken_vec   <= '0;
      taken_cnt   <= 0;
      wait_q      <= 4'h0;
      busy_q      <= 5'h0;
    end else begin
      cpu_irq_ack <= 1'b0;
      cpu_reti    <= (busy_q == 5'h1);
      if (busy_q != 5'h0) begin
        busy_q <= busy_q - 5'h1;
      end
      if (irq_req && !cpu_irq_ack && !full_cmd && busy_q == 5'h0) begin
        if (wait_q >= ack_wait) begin
          cpu_irq_ack <= 1'b1;
          taken_vec   <= irq_vector;
          taken_cnt   <= taken_cnt + 1;
          wait_q      <= 4'h0;
          busy_q      <= {1'b0, ack_wait} + 5'h4;
        end else begin
          wait_q <= wait_q + 4'h1;
        end
      end else begin
        wait_q <= 4'h0;
      end
    end
  end
endmodule : itb_cpu_model

/* dv/testbench.sv */
module testbench;
  import itb_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [19:0]      evt;
    logic [VEC_W-1:0] vec;
  } itb_row_s;

  localparam logic [3:0] ROW_VEC [20] = '{4'h2, 4'h2, 4'h2, 4'h2, 4'h2, 4'h2, 4'h3, 4'h3,
    4'h3, 4'h3, 4'h3, 4'h3, 4'h4, 4'h4, 4'h4, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8};
  localparam logic [3:0] PRIO [4] = '{4'h2, 4'h3, 4'h5, 4'h6};

  logic             hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq_req, wake;
  logic [31:0]      haddr, hwdata, hrdata, rd;
  logic [1:0]       htrans;
  logic [2:0]       hsize;
  logic [2:0]       sub_cnt = 3'h0;
  logic [19:0]      evt;
  logic             sub_tick, lv_low, lv_sense, full_cmd, cpu_irq_ack, cpu_reti, cpu_stack_full;
  logic [3:0]       ack_wait;
  logic [VEC_W-1:0] irq_vector, taken_vec;
  int               taken_cnt, t_take, c0, num_errors, n_tests, n_seen;
  int               cyc = 0;
  itb_row_s         rows [20];

  assign hready = hreadyout;

  itb_top #(.N_UART(2)) itb_top_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sub_clk_tick(sub_tick),
    .uart_event(evt[11:0]), .sim_event(evt[15:12]), .spi_event(evt[16]),
    .group_member_evt(evt[19:17]), .lv_supply_low(lv_low),
    .low_voltage_sense_input(lv_sense), .cpu_stack_full(cpu_stack_full),
    .cpu_irq_ack(cpu_irq_ack), .cpu_reti(cpu_reti), .irq_req(irq_req),
    .irq_vector(irq_vector), .wake(wake));

  itb_cpu_model itb_cpu_model_inst (
    .hclk(hclk), .hresetn(hresetn), .irq_req(irq_req), .irq_vector(irq_vector),
    .full_cmd(full_cmd), .ack_wait(ack_wait), .cpu_irq_ack(cpu_irq_ack),
    .cpu_reti(cpu_reti), .cpu_stack_full(cpu_stack_full), .taken_vec(taken_vec),
    .taken_cnt(taken_cnt));

  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  // Subsidiary clock: one enable pulse every 8 system cycles
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    sub_cnt <= sub_cnt + 3'h1;
    sub_tick <= (sub_cnt == 3'h6);
  end

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic step(inout int n);
    @(posedge hclk);
    n++;
    if (n > 6000) begin
      num_errors++;
      $display("[FAIL] wait expected event seen timeout");
      final_report();
    end
  endtask : step

  task automatic wait_rdy();
    int n;
    n = 0;
    step(n);
    while (hready !== 1'b1) step(n);
  endtask : wait_rdy

  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    check(nm, rd, e);
  endtask : rdc

  // Waits for the next vector, counted so one taken during a read is not missed
  task automatic wait_take();
    int n;
    n = 0;
    while (taken_cnt <= n_seen) step(n);
    n_seen++;
    t_take = cyc;
    while (cpu_reti !== 1'b1) step(n);
    @(posedge hclk);
  endtask : wait_take

  task automatic pulse(input logic [19:0] e);
    evt <= e;
    @(posedge hclk);
    evt <= 20'h0;
    @(posedge hclk);
  endtask : pulse

  task automatic tb_case(input logic [1:0] psc, input logic [7:0] a, input logic [3:0] v,
                         input int per);
    int t1;
    wr(ADDR_PSC, {30'h0, psc});
    wr(a, 32'h80);
    wait_take();
    wait_take();
    t1 = t_take;
    wait_take();
    check("tb_period", 32'(t_take - t1), 32'(per));
    check("tb_vector", {28'h0, taken_vec}, {28'h0, v});
    wr(a, 32'h0);
  endtask : tb_case

  initial begin
    {hresetn, hsel, hwrite, lv_low, lv_sense, full_cmd} = 6'h0;
    {haddr, hwdata, evt} = '0;
    htrans = 2'h0;
    hsize = 3'h2;
    ack_wait = 4'h0;
    for (int i = 0; i < 20; i++) rows[i] = '{20'h1 << i, ROW_VEC[i]};
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check("irq_req", {31'h0, irq_req}, 32'h0);
    rdc("tb0_ctrl", ADDR_TB0_CTRL, 32'h0);
    rdc("tb1_ctrl", ADDR_TB1_CTRL, 32'h0);
    rdc("prescaler", ADDR_PSC, 32'h0);
    rdc("flags", ADDR_FLAG, 32'h0);
    wr(ADDR_TB0_CTRL, 32'hffffffff);
    rdc("tb0_ctrl", ADDR_TB0_CTRL, 32'h87);
    wr(ADDR_TB1_CTRL, 32'h78);
    rdc("tb1_ctrl", ADDR_TB1_CTRL, 32'h0);
    wr(ADDR_TB0_CTRL, 32'h0);
    wr(ADDR_ENABLE, 32'h3ff);
    rdc("enable", ADDR_ENABLE, 32'h3ff);
    for (int i = 0; i < 20; i++) begin
      ack_wait <= 4'(i % 3);
      pulse(rows[i].evt);
      check("wake", {31'h0, wake}, 32'h1);
      wait_take();
      check("vector", {28'h0, taken_vec}, {28'h0, rows[i].vec});
      rdc("flags", ADDR_FLAG, 32'h0);
    end
    wr(ADDR_ENABLE, 32'h3fe);
    pulse(20'h1);
    repeat (2) @(posedge hclk);
    check("irq_req", {31'h0, irq_req}, 32'h0);
    full_cmd <= 1'b1;
    wr(ADDR_ENABLE, 32'h3ff);
    pulse(20'h30040);
    repeat (2) @(posedge hclk);
    check("irq_req", {31'h0, irq_req}, 32'h0);
    rdc("flags", ADDR_FLAG, 32'h6c);
    rdc("status", ADDR_STATUS, 32'h200);
    full_cmd <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      wait_take();
      check("prio_vec", {28'h0, taken_vec}, {28'h0, PRIO[i]});
      if (i == 0) rdc("flags", ADDR_FLAG, 32'h68);
    end
    wr(ADDR_ENABLE, 32'h10201);
    lv_low <= 1'b1;
    wait_take();
    check("lv_vec", {28'h0, taken_vec}, 32'h8);
    rdc("flags", ADDR_FLAG, 32'h10000);
    wr(ADDR_FLAG, 32'h10000);
    rdc("flags", ADDR_FLAG, 32'h0);
    lv_low <= 1'b0;
    @(posedge hclk);
    lv_sense <= 1'b1;
    wait_take();
    check("lv_vec", {28'h0, taken_vec}, 32'h8);
    wr(ADDR_FLAG, 32'h10000);
    lv_sense <= 1'b0;
    wr(ADDR_ENABLE, 32'h201);
    lv_low <= 1'b1;
    repeat (3) @(posedge hclk);
    check("irq_req", {31'h0, irq_req}, 32'h0);
    rdc("flags", ADDR_FLAG, 32'h10000);
    wr(ADDR_FLAG, 32'h10000);
    lv_low <= 1'b0;
    wr(ADDR_ENABLE, 32'h7);
    ack_wait <= 4'h0;
    tb_case(PSC_SYS, ADDR_TB0_CTRL, 4'h0, 256);
    tb_case(PSC_SYS_DIV4, ADDR_TB0_CTRL, 4'h0, 1024);
    tb_case(2'h2, ADDR_TB1_CTRL, 4'h1, 2048);
    repeat (300) @(posedge hclk);
    c0 = taken_cnt;
    repeat (600) @(posedge hclk);
    check("tb_idle", 32'(taken_cnt - c0), 32'h0);
    wr(ADDR_TB0_CTRL, 32'h87);
    rdc("tb0_ctrl", ADDR_TB0_CTRL, 32'h87);
    check("hresp", {31'h0, hresp}, 32'h0);
    hresetn <= 1'b0;
    @(posedge hclk);
    check("rst_rdata", hrdata, 32'h0);
    hresetn <= 1'b1;
    n_seen = 0;
    @(posedge hclk);
    rdc("tb0_ctrl", ADDR_TB0_CTRL, 32'h0);
    final_report();
  end
endmodule : testbench
